// ==== design/rx_status_and_tx_dma_setup.sv ====
// Behaviour
// - good packet: status byte stored with packet
// - errors saved: status written ahead of packet
// - errors rejected: no status byte written
// - status cleared when next packet arrives
// - intact bit only when no error flags
// - crc bit on crc or alignment error
// - alignment bit on dribble with bad crc
// - overrun bit set, packet reception aborted
// - missed bit on no buffer or monitor
// - address type bit, multicast is one
// - disabled bit follows monitor mode
// - deferring bit follows carrier sense, collision
// - alignment without crc error never encoded
// - registers are 8 bits, count split
// - page start holds address bits 15-8
// - transmit start loads page, low byte zero
// - full 16-bit length, no truncation
// - tallies stop at 192, clear on read
`timescale 1ns/1ps
`default_nettype none

module rx_status_and_tx_dma_setup (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // receive events from the mac, same clock
  input  wire logic        rx_arrive,
  input  wire logic        rx_end,
  input  wire logic        rx_crc_bad,
  input  wire logic        rx_dribble,
  input  wire logic        rx_overrun,
  input  wire logic        rx_no_buffer,
  input  wire logic        rx_multicast,
  // codec line pins, asynchronous
  input  wire logic        carrier_sense,
  input  wire logic        collision_detect_line,
  // status byte store request to local dma
  output logic             stat_wr_valid,
  input  wire logic        stat_wr_ready,
  output logic [7:0]       stat_wr_data,
  output logic             rx_abort,
  // transmit setup to local dma
  output logic             tx_go,
  output logic [15:0]      tx_dma_addr,
  output logic [15:0]      tx_length
);

  // all state of the block in one record
  typedef struct packed {
    rx_status_pkg::bus_phase_t phase;   // bus transfer phase
    logic [7:0]  addr;                  // latched word offset
    logic        cfg_save;              // keep errored packets
    logic        cfg_mon;               // monitor mode
    logic [7:0]  page_start;            // transmit page
    logic [7:0]  cnt_low;               // transmit count low
    logic [7:0]  cnt_high;              // transmit count high
    logic [5:0]  status;                // latched status bits
    logic [7:0]  tally_align;           // alignment errors
    logic [7:0]  tally_crc;             // crc errors
    logic [7:0]  tally_missed;          // missed packets
    logic        crs_s1;                // carrier sync stage 1
    logic        crs_s2;                // carrier sync stage 2
    logic        col_s1;                // collision sync stage 1
    logic        col_s2;                // collision sync stage 2
    logic        wr_valid;              // status store pending
    logic [7:0]  wr_data;               // status byte to store
    logic        abort;                 // abort pulse
    logic        go;                    // transmit start pulse
    logic [15:0] dma_addr;              // transmit dma address
    logic [15:0] length;                // transmit length
    logic [31:0] rdata;                 // read data
  } state_t;

  state_t st_q;  // registered state
  state_t st_d;  // next state

  // saturating tally step; a clearing read applies first, then the increment
  function automatic logic [7:0] tally_next(
    input logic [7:0] cur,
    input logic       inc,
    input logic       clr
  );
    logic [7:0] base;
    base = clr ? rx_status_pkg::RST_BYTE : cur;
    if (inc && base < rx_status_pkg::TALLY_MAX)
    begin
      tally_next = base + 8'h01;
    end
    else
    begin
      tally_next = base;
    end
  endfunction : tally_next

  // live status byte as software sees it
  function automatic logic [7:0] status_byte(
    input state_t s
  );
    logic [7:0] b;
    b = {2'b00, s.status};
    b[rx_status_pkg::RS_DISABLED] = s.cfg_mon;
    b[rx_status_pkg::RS_DEFER] = s.crs_s2 | s.col_s2;
    status_byte = b;
  endfunction : status_byte

  // bus request taken in the address phase
  logic       take;
  // packet classification at packet end
  logic       pk_crc;
  logic       pk_align;
  logic       pk_over;
  logic       pk_miss;
  logic       pk_good;
  logic       pk_store;
  // read that clears a tally this cycle
  logic       rd_align;
  logic       rd_crc;
  logic       rd_miss;
  // write applied this cycle
  logic       wr_now;
  logic [7:0] wbyte;
  // status byte as a read would show it this cycle; a function result
  // cannot be part-selected, so it is held in a variable of its own
  logic [7:0] sb_live;

  // an address phase counts only when the bus is ready; idle and busy
  // transfers are dropped here, so they never open a data phase
  assign take = hsel && htrans[1] && hready;

  // next state
  always_comb
  begin
    // hold everything by default; pulses fall back to zero each cycle
    st_d = st_q;
    st_d.abort = 1'b0;
    st_d.go = 1'b0;
    sb_live = status_byte(st_q);

    // level pins pass two flops before use
    // only the second stage is read anywhere, so a metastable first
    // stage never reaches the status byte
    st_d.crs_s1 = carrier_sense;
    st_d.crs_s2 = st_q.crs_s1;
    st_d.col_s1 = collision_detect_line;
    st_d.col_s2 = st_q.col_s1;

    // packet end classification
    // the flags are levels valid only with rx_end; outside it these
    // terms are computed but nothing uses them
    pk_crc   = rx_crc_bad;
    pk_align = rx_crc_bad && rx_dribble;
    // an overrun pulse earlier in the same packet still counts here
    pk_over  = st_q.status[rx_status_pkg::RS_OVERRUN] || rx_overrun;
    pk_miss  = rx_no_buffer || st_q.cfg_mon;
    pk_good  = !pk_crc && !pk_align && !pk_over && !pk_miss;
    // errored packets only stored when saving is on
    pk_store = !pk_over && !pk_miss &&
               (pk_good || st_q.cfg_save);

    // a write lands in the cycle after its address phase
    wr_now = (st_q.phase == rx_status_pkg::BUS_WRITE);
    wbyte  = hwdata[7:0];

    // tally reads clear in the wait cycle of the read
    // the read mux samples the old count on the same edge, so software
    // sees exactly the value that was cleared
    rd_align = 1'b0;
    rd_crc   = 1'b0;
    rd_miss  = 1'b0;
    if (st_q.phase == rx_status_pkg::BUS_READ)
    begin
      case (st_q.addr)
        rx_status_pkg::OFS_ALIGN_TALLY:  rd_align = 1'b1;
        rx_status_pkg::OFS_CRC_TALLY:    rd_crc = 1'b1;
        rx_status_pkg::OFS_MISSED_TALLY: rd_miss = 1'b1;
        default:                         rd_align = 1'b0;
      endcase
    end

    // receive status tracking
    // order matters: the arrival clear comes first, so an overrun or a
    // packet end in the same cycle still leaves its bits set
    if (rx_arrive)
    begin
      // a new packet wipes the previous record
      st_d.status = rx_status_pkg::RST_STATUS;
    end
    if (rx_overrun)
    begin
      // fifo not serviced, give the packet up now
      st_d.status[rx_status_pkg::RS_OVERRUN] = 1'b1;
      st_d.abort = 1'b1;
    end
    if (rx_end)
    begin
      st_d.status[rx_status_pkg::RS_INTACT]   = pk_good;
      st_d.status[rx_status_pkg::RS_CRC]      = pk_crc;
      st_d.status[rx_status_pkg::RS_ALIGN]    = pk_align;
      st_d.status[rx_status_pkg::RS_OVERRUN]  = pk_over;
      st_d.status[rx_status_pkg::RS_MISSED]   = pk_miss;
      st_d.status[rx_status_pkg::RS_ADDRTYPE] = rx_multicast;
    end

    // tallies; an event and a clearing read in one cycle keep the event
    // a tally at its ceiling simply stops; it never wraps to zero
    st_d.tally_crc = tally_next(st_q.tally_crc,
                                rx_end && pk_crc, rd_crc);
    st_d.tally_align = tally_next(st_q.tally_align,
                                  rx_end && pk_align, rd_align);
    st_d.tally_missed = tally_next(st_q.tally_missed,
                                   rx_end && pk_miss, rd_miss);

    // status store request toward the local dma
    // the dma may hold ready low for any time; the byte stays put
    // until it is taken, unless a later packet end overwrites it
    if (st_q.wr_valid && stat_wr_ready)
    begin
      st_d.wr_valid = 1'b0;
    end
    if (rx_end && pk_store)
    begin
      // a newer packet replaces an unserved request
      st_d.wr_valid = 1'b1;
      // the two live bits are copied as they stand at packet end
      st_d.wr_data = {sb_live[7:6], rx_multicast,
                      pk_miss, pk_over, pk_align, pk_crc, pk_good};
    end

    // register writes
    // only the low byte of hwdata matters; wider sizes are not refused
    if (wr_now)
    begin
      case (st_q.addr)
        rx_status_pkg::OFS_RX_CONFIG:
        begin
          st_d.cfg_save = wbyte[rx_status_pkg::CFG_SAVE_ERRORED];
          st_d.cfg_mon  = wbyte[rx_status_pkg::CFG_MONITOR];
        end
        rx_status_pkg::OFS_TX_PAGE_START:
        begin
          st_d.page_start = wbyte;
        end
        rx_status_pkg::OFS_TX_COUNT_LOW:
        begin
          st_d.cnt_low = wbyte;
        end
        rx_status_pkg::OFS_TX_COUNT_HIGH:
        begin
          st_d.cnt_high = wbyte;
        end
        rx_status_pkg::OFS_TX_COMMAND:
        begin
          if (wbyte[rx_status_pkg::CMD_TX_START])
          begin
            // page in the high byte, low byte from zero
            st_d.dma_addr = {st_q.page_start,
                             rx_status_pkg::TX_PAGE_OFFSET};
            // whole 16-bit count passes, never clipped
            st_d.length = {st_q.cnt_high, st_q.cnt_low};
            st_d.go = 1'b1;
          end
        end
        default:
        begin
          // status, tallies and holes ignore writes
          st_d.cfg_save = st_q.cfg_save;
        end
      endcase
    end

    // bus phase sequencing
    case (st_q.phase)
      rx_status_pkg::BUS_READ:
      begin
        // one wait cycle lets a preceding write settle first
        // the cost is one stalled cycle per read; writes never stall
        case (st_q.addr)
          rx_status_pkg::OFS_RX_CONFIG:
            st_d.rdata = {30'h0000_0000, st_q.cfg_mon, st_q.cfg_save};
          rx_status_pkg::OFS_TX_PAGE_START:
            st_d.rdata = {24'h00_0000, st_q.page_start};
          rx_status_pkg::OFS_TX_COUNT_LOW:
            st_d.rdata = {24'h00_0000, st_q.cnt_low};
          rx_status_pkg::OFS_TX_COUNT_HIGH:
            st_d.rdata = {24'h00_0000, st_q.cnt_high};
          rx_status_pkg::OFS_RX_STATUS:
            st_d.rdata = {24'h00_0000, status_byte(st_q)};
          rx_status_pkg::OFS_ALIGN_TALLY:
            st_d.rdata = {24'h00_0000, st_q.tally_align};
          rx_status_pkg::OFS_CRC_TALLY:
            st_d.rdata = {24'h00_0000, st_q.tally_crc};
          rx_status_pkg::OFS_MISSED_TALLY:
            st_d.rdata = {24'h00_0000, st_q.tally_missed};
          default:
            st_d.rdata = rx_status_pkg::RST_WORD;
        endcase
        st_d.phase = rx_status_pkg::BUS_RDATA;
      end
      default:
      begin
        // ready cycle: a new address phase may be taken
        // this covers the idle, write data and read data cycles alike,
        // which is what lets transfers run back to back
        if (take)
        begin
          st_d.addr = {haddr[7:2], 2'b00};
          st_d.phase = hwrite ? rx_status_pkg::BUS_WRITE
                              : rx_status_pkg::BUS_READ;
        end
        else
        begin
          st_d.phase = rx_status_pkg::BUS_IDLE;
        end
        // an address beyond the block window maps to a hole
        // offset 0xfc decodes to nothing, so such reads return zero
        if (take && haddr[31:8] != 24'h00_0000)
        begin
          st_d.addr = 8'hfc;
        end
      end
    endcase
  end

  // state register
  // reset clears every field, the status byte too, which has no
  // defined value before the first packet anyway
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // bus answers; only the read wait cycle stalls
  // errors are never signalled: unmapped and read-only targets answer
  // okay and simply ignore the write
  assign hreadyout = (st_q.phase != rx_status_pkg::BUS_READ);
  assign hresp     = 1'b0;
  assign hrdata    = st_q.rdata;

  // dma side outputs straight from flops
  // each is a register field, so no glitch reaches the dma
  assign stat_wr_valid = st_q.wr_valid;
  assign stat_wr_data  = st_q.wr_data;
  assign rx_abort      = st_q.abort;
  assign tx_go         = st_q.go;
  assign tx_dma_addr   = st_q.dma_addr;
  assign tx_length     = st_q.length;

  // hsize is not checked: any size moves the low byte
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[1:0], hwdata[31:8], htrans[0]};

endmodule : rx_status_and_tx_dma_setup

`default_nettype wire

// ==== design/rx_status_pkg.sv ====
package rx_status_pkg;

  // register byte offsets on the bus, one 32-bit word each
  localparam logic [7:0] OFS_RX_CONFIG     = 8'h00;
  localparam logic [7:0] OFS_TX_PAGE_START = 8'h04;
  localparam logic [7:0] OFS_TX_COUNT_LOW  = 8'h08;
  localparam logic [7:0] OFS_RX_STATUS     = 8'h0c;
  localparam logic [7:0] OFS_TX_COUNT_HIGH = 8'h10;
  localparam logic [7:0] OFS_ALIGN_TALLY   = 8'h14;
  localparam logic [7:0] OFS_CRC_TALLY     = 8'h18;
  localparam logic [7:0] OFS_MISSED_TALLY  = 8'h1c;
  localparam logic [7:0] OFS_TX_COMMAND    = 8'h20;

  // receive status bit positions
  localparam int RS_INTACT   = 0;
  localparam int RS_CRC      = 1;
  localparam int RS_ALIGN    = 2;
  localparam int RS_OVERRUN  = 3;
  localparam int RS_MISSED   = 4;
  localparam int RS_ADDRTYPE = 5;
  localparam int RS_DISABLED = 6;
  localparam int RS_DEFER    = 7;

  // configuration and command bit positions
  localparam int CFG_SAVE_ERRORED = 0;
  localparam int CFG_MONITOR      = 1;
  localparam int CMD_TX_START     = 0;

  // reset values
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [5:0] RST_STATUS   = 6'h00;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;

  // tally counters stop at this count
  localparam logic [7:0] TALLY_MAX = 8'hc0;

  // low address byte at transmit start, pages are 256 bytes
  localparam logic [7:0] TX_PAGE_OFFSET = 8'h00;

  // bus handling phases
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b10,
    BUS_RDATA = 2'b11
  } bus_phase_t;

endpackage : rx_status_pkg

// ==== dv/dma_status_sink.sv ====
`timescale 1ns/1ps
`default_nettype none

module dma_status_sink (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // status byte store request
  input wire logic       stat_wr_valid,
  input wire logic [7:0] stat_wr_data,
  output logic           stat_wr_ready,
  // test controls and observations
  input wire logic       slow,
  output logic [7:0]     taken_cnt,
  output logic [7:0]     last_byte
);
  logic [1:0] wait_q; // cycles the request has stood

  // slow mode makes the design hold its request four cycles
  assign stat_wr_ready = stat_wr_valid && (!slow || wait_q == 2'd3);

  // take the byte into buffer memory at valid and ready
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wait_q    <= 2'd0;
      taken_cnt <= 8'h00;
      last_byte <= 8'h00;
    end
    else if (stat_wr_valid && !stat_wr_ready)
      wait_q <= wait_q + 2'd1;
    else
    begin
      wait_q <= 2'd0;
      if (stat_wr_valid)
      begin
        taken_cnt <= taken_cnt + 8'h01;
        last_byte <= stat_wr_data;
      end
    end
  end
endmodule : dma_status_sink

`default_nettype wire

// ==== dv/rx_status_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module rx_status_checker (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus answer
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // receive events
  input wire logic        rx_end,
  input wire logic        rx_crc_bad,
  input wire logic        rx_dribble,
  input wire logic        rx_overrun,
  input wire logic        rx_no_buffer,
  input wire logic        rx_multicast,
  // status store and transmit setup
  input wire logic        stat_wr_valid,
  input wire logic        stat_wr_ready,
  input wire logic [7:0]  stat_wr_data,
  input wire logic        rx_abort,
  input wire logic        tx_go,
  input wire logic [15:0] tx_dma_addr
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // packet end seen while no store is pending
  sequence s_end_free;
    rx_end && !stat_wr_valid;
  endsequence
  // store offered but not yet taken, no overwrite coming
  sequence s_store_wait;
    stat_wr_valid && !stat_wr_ready && !rx_end;
  endsequence

  property p_store_hold;
    s_store_wait |=> stat_wr_valid && $stable(stat_wr_data);
  endproperty
  a_store_hold: assert property (p_store_hold)
    else $error("status store dropped before taken");
  property p_intact;
    stat_wr_valid && stat_wr_data[0] |-> stat_wr_data[4:1] == 4'h0;
  endproperty
  a_intact: assert property (p_intact)
    else $error("intact flag beside error flags");
  property p_err_code;
    stat_wr_valid |-> !(stat_wr_data[2] && !stat_wr_data[1]);
  endproperty
  a_err_code: assert property (p_err_code)
    else $error("alignment without crc flag");
  property p_abort;
    rx_overrun |=> rx_abort;
  endproperty
  a_abort: assert property (p_abort)
    else $error("overrun did not abort");
  property p_missed;
    s_end_free and rx_no_buffer |=> !stat_wr_valid;
  endproperty
  a_missed: assert property (p_missed)
    else $error("missed packet stored");
  // the byte offered must carry the crc, alignment and address type flags given at packet end
  property p_class;
    s_end_free |=> !stat_wr_valid
      || (stat_wr_data[1] == $past(rx_crc_bad)
      && stat_wr_data[2] == $past(rx_crc_bad && rx_dribble)
      && stat_wr_data[5] == $past(rx_multicast));
  endproperty
  a_class: assert property (p_class)
    else $error("stored flags differ from packet end");
  property p_tx_page;
    tx_go |-> tx_dma_addr[7:0] == 8'h00;
  endproperty
  a_tx_page: assert property (p_tx_page)
    else $error("transmit low address not zero");
  property p_byte_bus;
    hresp == 1'b0 && hrdata[31:8] == 24'h0;
  endproperty
  a_byte_bus: assert property (p_byte_bus)
    else $error("bus answer wider than a byte");
endmodule : rx_status_checker

bind rx_status_and_tx_dma_setup rx_status_checker u_rx_status_checker (
  .hclk, .hresetn, .hresp, .hrdata, .rx_end, .rx_crc_bad, .rx_dribble,
  .rx_overrun, .rx_no_buffer, .rx_multicast, .stat_wr_valid,
  .stat_wr_ready, .stat_wr_data, .rx_abort, .tx_go, .tx_dma_addr
);

`default_nettype wire

// ==== dv/test_rx_status_and_tx_dma_setup.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_rx_status_and_tx_dma_setup;
  typedef struct packed {
    logic       save;  // keep errored packets
    logic [4:0] f;     // crc, dribble, overrun, no buffer, multicast
    logic [7:0] st;    // status byte expected
    logic       store; // byte should go to memory
  } row_t;
  localparam row_t rows [8] = '{
    '{1'b0, 5'b00000, 8'h01, 1'b1}, '{1'b0, 5'b00001, 8'h21, 1'b1},
    '{1'b0, 5'b10000, 8'h02, 1'b0}, '{1'b1, 5'b10000, 8'h02, 1'b1},
    '{1'b1, 5'b11001, 8'h26, 1'b1}, '{1'b1, 5'b01000, 8'h01, 1'b1},
    '{1'b1, 5'b00100, 8'h08, 1'b0}, '{1'b0, 5'b00010, 8'h10, 1'b0}};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_arrive, rx_end;
  logic rx_crc_bad, rx_dribble, rx_overrun, rx_no_buffer, rx_multicast;
  logic carrier_sense, collision_detect_line, stat_wr_valid, rx_abort;
  logic stat_wr_ready, tx_go, slow;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [7:0]  stat_wr_data, taken_cnt, last_byte, n0;
  logic [15:0] tx_dma_addr, tx_length;
  int          mismatches, num_checks;

  rx_status_and_tx_dma_setup u_rx_status_and_tx_dma_setup (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_arrive, .rx_end,
    .rx_crc_bad, .rx_dribble, .rx_overrun, .rx_no_buffer, .rx_multicast,
    .carrier_sense, .collision_detect_line, .stat_wr_valid, .stat_wr_ready,
    .stat_wr_data, .rx_abort, .tx_go, .tx_dma_addr, .tx_length);
  dma_status_sink u_dma_status_sink (
    .hclk, .hresetn, .stat_wr_valid, .stat_wr_data, .stat_wr_ready, .slow,
    .taken_cnt, .last_byte);

  always #2 hclk = ~hclk;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, exp, input string m);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, seen, exp);
    end
  endtask : chk

  // address phase held until ready, then data phase until ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(v, {24'h0, e}, "read");
  endtask : rd_chk

  // one packet: arrival, then its end with the flags
  task automatic pkt(input logic [4:0] f);
    @(posedge hclk);
    rx_arrive <= 1'b1;
    @(posedge hclk);
    rx_arrive <= 1'b0;
    rx_end <= 1'b1;
    {rx_crc_bad, rx_dribble, rx_overrun, rx_no_buffer, rx_multicast} <= f;
    @(posedge hclk);
    rx_end <= 1'b0;
    {rx_crc_bad, rx_dribble, rx_overrun, rx_no_buffer, rx_multicast} <= 5'h0;
    #1;
  endtask : pkt

  initial
  begin
    #100us;
    mismatches++;
    stop_test();
  end

  initial
  begin
    {hclk, hresetn, hsel, hwrite, rx_arrive, rx_end, rx_crc_bad} = 7'h0;
    {rx_dribble, rx_overrun, rx_no_buffer, rx_multicast, slow} = 5'h0;
    {carrier_sense, collision_detect_line, htrans} = 4'h0;
    {haddr, hwdata, hsize} = {32'h0, 32'h0, 3'h2};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(rx_status_pkg::OFS_RX_CONFIG, 8'h00);
    rd_chk(rx_status_pkg::OFS_TX_PAGE_START, 8'h00);
    $display("test reset done");
    foreach (rows[i])
    begin
      slow <= i[0];
      bus(1'b1, rx_status_pkg::OFS_RX_CONFIG, {7'h0, rows[i].save});
      n0 = taken_cnt;
      pkt(rows[i].f);
      chk(stat_wr_valid, rows[i].store, "store offered");
      chk(rx_abort, rows[i].f[2], "abort");
      for (int k = 0; k < 20 && stat_wr_valid === 1'b1; k++)
        @(posedge hclk);
      #1;
      chk(taken_cnt, n0 + rows[i].store, "stores taken");
      if (rows[i].store)
        chk(last_byte, rows[i].st, "stored byte");
      rd_chk(rx_status_pkg::OFS_RX_STATUS, rows[i].st);
      $display("test row %0d done", i);
    end
    rd_chk(rx_status_pkg::OFS_CRC_TALLY, 8'h03);
    rd_chk(rx_status_pkg::OFS_ALIGN_TALLY, 8'h01);
    rd_chk(rx_status_pkg::OFS_MISSED_TALLY, 8'h01);
    rd_chk(rx_status_pkg::OFS_CRC_TALLY, 8'h00);
    bus(1'b1, rx_status_pkg::OFS_RX_STATUS, 8'hff);
    rd_chk(rx_status_pkg::OFS_RX_STATUS, 8'h10);
    rd_chk(rx_status_pkg::OFS_RX_STATUS, 8'h10);
    bus(1'b1, 8'h3c, 8'h5a);
    rd_chk(8'h3c, 8'h00);
    @(posedge hclk);
    rx_arrive <= 1'b1;
    @(posedge hclk);
    rx_arrive <= 1'b0;
    rd_chk(rx_status_pkg::OFS_RX_STATUS, 8'h00);
    $display("test access done");
    bus(1'b1, rx_status_pkg::OFS_RX_CONFIG, 8'h02);
    pkt(5'b00000);
    chk(stat_wr_valid, 1'b0, "monitor store");
    rd_chk(rx_status_pkg::OFS_RX_STATUS, 8'h50);
    rd_chk(rx_status_pkg::OFS_MISSED_TALLY, 8'h01);
    bus(1'b1, rx_status_pkg::OFS_RX_CONFIG, 8'h00);
    rd_chk(rx_status_pkg::OFS_RX_STATUS, 8'h10);
    carrier_sense <= 1'b1;
    rd_chk(rx_status_pkg::OFS_RX_STATUS, 8'h90);
    {carrier_sense, collision_detect_line} <= 2'b01;
    repeat (3) @(posedge hclk);
    rd_chk(rx_status_pkg::OFS_RX_STATUS, 8'h90);
    collision_detect_line <= 1'b0;
    $display("test monitor and defer done");
    repeat (200) pkt(5'b10000);
    rd_chk(rx_status_pkg::OFS_CRC_TALLY, rx_status_pkg::TALLY_MAX);
    rd_chk(rx_status_pkg::OFS_CRC_TALLY, 8'h00);
    $display("test tally limit done");
    // page aligned packet, count covering all fields
    bus(1'b1, rx_status_pkg::OFS_TX_PAGE_START, 8'ha5);
    bus(1'b1, rx_status_pkg::OFS_TX_COUNT_LOW, 8'hff);
    bus(1'b1, rx_status_pkg::OFS_TX_COUNT_HIGH, 8'hff);
    rd_chk(rx_status_pkg::OFS_TX_PAGE_START, 8'ha5);
    bus(1'b1, rx_status_pkg::OFS_TX_COMMAND, 8'h01);
    // tx_go stands one cycle: look for it mid-cycle, not after an edge
    for (int k = 0; k < 5 && tx_go !== 1'b1; k++)
      @(negedge hclk);
    chk(tx_go, 1'b1, "transmit start");
    chk(tx_dma_addr, 16'ha500, "transmit address");
    chk(tx_length, 16'hffff, "transmit length");
    $display("test transmit done");
    stop_test();
  end
endmodule : test_rx_status_and_tx_dma_setup

`default_nettype wire
